// ---- verilog/spcl_strap_latch.v ----
`timescale 1ns/1ps
`include "spcl_defs.vh"

// How it works
// - Three address straps sampled at reset release form address bits 2:0.
// - Address low bits range 0 to 7; unstrapped pulls give address 1.
// - Address 0 is broadcast unless disable strap high or software bit set.
// - Address bits 4:3 are always 00, no strap drives them.
// - Code at release: 000 normal, 110 back-to-back, others reserved.
// - Wake output enable strap copied to register 16h bit 15.
// - Isolate strap copied to register 0h bit 10; high enables isolate.
// - Duplex strap copied to register 0h bit 8; high means half duplex.
// - Auto-negotiation strap copied to register 0h bit 12.

module spcl_strap_latch (
	input wire clk_i,
	input wire reset_i,
	input wire [10:0] strap_pin_i,
	output wire [10:0] strap_pin_o,
	output wire [10:0] strap_pin_oe_o,
	input wire [10:0] func_out_i,
	input wire bcast_disable_wr_i,
	input wire bcast_disable_wdata_i,
	input wire [4:0] mgmt_addr_i,
	output wire straps_valid_o,
	output wire [4:0] strap_phy_address_o,
	output wire broadcast_enable_o,
	output wire addr_hit_o,
	output wire [2:0] config_mode_o,
	output wire back_to_back_o,
	output wire config_reserved_o,
	output wire reg16_wake_enable_o,
	output wire reg16_bcast_disable_o,
	output wire reg0_isolate_o,
	output wire reg0_duplex_o,
	output wire reg0_autoneg_o
);

// ==================================================
// Sequencer
// One cycle in hold after release is enough because the strap inputs
// are synchronous; the capture lands on the first edge after release.
reg [1:0] state_reg;
reg [1:0] state_next;
reg capture_w;
reg drive_w;

// Two states suffice: one capture edge, then running until reset
localparam [1:0] ST_HOLD = `SPCL_ST_HOLD;
localparam [1:0] ST_RUN = `SPCL_ST_RUN;

always @* begin
	state_next = state_reg;
	capture_w = 1'b0;
	drive_w = 1'b0;
	case (state_reg)
	ST_HOLD: begin
		capture_w = 1'b1;
		state_next = ST_RUN;
	end
	ST_RUN: begin
		drive_w = 1'b1;
	end
	default: begin
		state_next = ST_HOLD;
	end
	endcase
end

always @(posedge clk_i or posedge reset_i) begin
	if (reset_i) begin
		state_reg <= ST_HOLD;
	end else begin
		state_reg <= state_next;
	end
end

// ==================================================
// Per-pin capture cells
wire [10:0] strap_cap_w;
localparam [10:0] STRAP_DEFAULT = `SPCL_STRAP_DEFAULT;

genvar gi;
generate
	for (gi = 0; gi < `SPCL_NPINS; gi = gi + 1) begin : g_pin
		spcl_pin_cell #(
			.DEFAULT_LEVEL(STRAP_DEFAULT[gi])
		) u_cell (
			.clk_i(clk_i),
			.reset_i(reset_i),
			.capture_i(capture_w),
			.drive_i(drive_w),
			.pin_in_i(strap_pin_i[gi]),
			.func_out_i(func_out_i[gi]),
			.captured_o(strap_cap_w[gi]),
			.pin_out_o(strap_pin_o[gi]),
			.pin_oe_o(strap_pin_oe_o[gi])
		);
	end
endgenerate

// ==================================================
// Software broadcast disable, register 16h bit 9
reg bcast_sw_reg;

always @(posedge clk_i or posedge reset_i) begin
	if (reset_i) begin
		bcast_sw_reg <= 1'b0;
	end else if (bcast_disable_wr_i) begin
		bcast_sw_reg <= bcast_disable_wdata_i;
	end
end

// ==================================================
// Decoded configuration
wire [2:0] strap_phy_address_w;
wire [2:0] cfg_w;
wire bcast_off_w;
wire [4:0] addr_w;

assign strap_phy_address_w = strap_cap_w[`SPCL_STRAP_PHY_ADDRESS_MSB:`SPCL_STRAP_PHY_ADDRESS_LSB];
assign cfg_w = strap_cap_w[`SPCL_CFG_MSB:`SPCL_CFG_LSB];
// Either source turns address 0 into a unique address
assign bcast_off_w = strap_cap_w[`SPCL_BCAST_BIT] | bcast_sw_reg;
// Upper address bits have no strap
assign addr_w = {`SPCL_ADDR_UPPER, strap_phy_address_w};

// ==================================================
// Output stage
// Outputs come from flops so that nothing glitches while capture settles
reg straps_valid_reg;
reg straps_valid_next;
reg [4:0] phy_address_reg;
reg [4:0] phy_address_next;
reg bcast_enable_reg;
reg bcast_enable_next;
reg addr_hit_reg;
reg addr_hit_next;

// Captured configuration held until the next reset, plus the software broadcast disable bit
reg [2:0] config_mode_reg;
reg [2:0] config_mode_next;
reg back_to_back_reg;
reg back_to_back_next;
reg config_reserved_reg;
reg config_reserved_next;
reg wake_enable_reg;
reg wake_enable_next;
reg bcast_disable_reg;
reg bcast_disable_next;
reg isolate_reg;
reg isolate_next;
reg duplex_reg;
reg duplex_next;
reg autoneg_reg;
reg autoneg_next;

always @* begin
	straps_valid_next = drive_w;
	phy_address_next = addr_w;
	bcast_enable_next = ~bcast_off_w;
	// Once running, own address hits; address 0 also hits while broadcast is enabled
	addr_hit_next = drive_w &
		((mgmt_addr_i == addr_w) |
		((mgmt_addr_i == `SPCL_ADDR_ZERO) & ~bcast_off_w));
	config_mode_next = cfg_w;
	back_to_back_next = (cfg_w == `SPCL_CFG_B2B);
	// Reserved codes are flagged, the block still runs as normal
	config_reserved_next = (cfg_w != `SPCL_CFG_NORMAL) &
		(cfg_w != `SPCL_CFG_B2B);
	wake_enable_next = strap_cap_w[`SPCL_WAKE_BIT];
	bcast_disable_next = bcast_sw_reg;
	isolate_next = strap_cap_w[`SPCL_ISO_BIT];
	duplex_next = strap_cap_w[`SPCL_DUPLEX_BIT];
	autoneg_next = strap_cap_w[`SPCL_NWAY_BIT];
end

always @(posedge clk_i or posedge reset_i) begin
	if (reset_i) begin
		straps_valid_reg <= 1'b0;
		phy_address_reg <= {`SPCL_ADDR_UPPER,
			STRAP_DEFAULT[`SPCL_STRAP_PHY_ADDRESS_MSB:`SPCL_STRAP_PHY_ADDRESS_LSB]};
		bcast_enable_reg <= ~STRAP_DEFAULT[`SPCL_BCAST_BIT];
		addr_hit_reg <= 1'b0;
		config_mode_reg <= `SPCL_CFG_NORMAL;
		back_to_back_reg <= 1'b0;
		config_reserved_reg <= 1'b0;
		wake_enable_reg <= STRAP_DEFAULT[`SPCL_WAKE_BIT];
		bcast_disable_reg <= 1'b0;
		isolate_reg <= STRAP_DEFAULT[`SPCL_ISO_BIT];
		duplex_reg <= STRAP_DEFAULT[`SPCL_DUPLEX_BIT];
		autoneg_reg <= STRAP_DEFAULT[`SPCL_NWAY_BIT];
	end else begin
		straps_valid_reg <= straps_valid_next;
		phy_address_reg <= phy_address_next;
		bcast_enable_reg <= bcast_enable_next;
		addr_hit_reg <= addr_hit_next;
		config_mode_reg <= config_mode_next;
		back_to_back_reg <= back_to_back_next;
		config_reserved_reg <= config_reserved_next;
		wake_enable_reg <= wake_enable_next;
		bcast_disable_reg <= bcast_disable_next;
		isolate_reg <= isolate_next;
		duplex_reg <= duplex_next;
		autoneg_reg <= autoneg_next;
	end
end

assign straps_valid_o = straps_valid_reg;
assign strap_phy_address_o = phy_address_reg;
assign broadcast_enable_o = bcast_enable_reg;
assign addr_hit_o = addr_hit_reg;
assign config_mode_o = config_mode_reg;
assign back_to_back_o = back_to_back_reg;
assign config_reserved_o = config_reserved_reg;

// Register 16h and 0h images
assign reg16_wake_enable_o = wake_enable_reg;
assign reg16_bcast_disable_o = bcast_disable_reg;
assign reg0_isolate_o = isolate_reg;
assign reg0_duplex_o = duplex_reg;
assign reg0_autoneg_o = autoneg_reg;

endmodule

// ---- verilog/spcl_defs.vh ----
`ifndef SPCL_DEFS_VH
`define SPCL_DEFS_VH

// ==================================================
// Strap pin vector layout
`define SPCL_NPINS 11
`define SPCL_STRAP_PHY_ADDRESS_LSB 0
`define SPCL_STRAP_PHY_ADDRESS_MSB 2
`define SPCL_CFG_LSB 3
`define SPCL_CFG_MSB 5
`define SPCL_WAKE_BIT 6
`define SPCL_ISO_BIT 7
`define SPCL_DUPLEX_BIT 8
`define SPCL_NWAY_BIT 9
`define SPCL_BCAST_BIT 10

// ==================================================
// Values that the internal pulls give with nothing strapped
`define SPCL_STRAP_DEFAULT 11'h301

// ==================================================
// Address and interface mode encodings
`define SPCL_ADDR_UPPER 2'h0
`define SPCL_ADDR_ZERO 5'h00
`define SPCL_CFG_NORMAL 3'h0
`define SPCL_CFG_B2B 3'h6

// ==================================================
// Sequencer states
`define SPCL_ST_HOLD 2'h0
`define SPCL_ST_RUN 2'h1

`endif

// ---- verilog/spcl_pin_cell.v ----
`timescale 1ns/1ps
`include "spcl_defs.vh"

module spcl_pin_cell #(
	parameter DEFAULT_LEVEL = 1'b0
) (
	input wire clk_i,
	input wire reset_i,
	input wire capture_i,
	input wire drive_i,
	input wire pin_in_i,
	input wire func_out_i,
	output reg captured_o,
	output reg pin_out_o,
	output reg pin_oe_o
);

// ==================================================
// Strap capture and pin drive
// The reset value is the pull level, so a capture that never ran
// still leaves the documented default in place.
always @(posedge clk_i or posedge reset_i) begin
	if (reset_i) begin
		captured_o <= DEFAULT_LEVEL;
		pin_out_o <= 1'b0;
		pin_oe_o <= 1'b0;
	end else begin
		if (capture_i) begin
			captured_o <= pin_in_i;
		end
		// Pin stays an input until the strap has been sampled
		pin_oe_o <= drive_i;
		pin_out_o <= drive_i ? func_out_i : 1'b0;
	end
end

endmodule

// ---- verif/spcl_straps.sv ----
`timescale 1ns/1ps
// ====
// Board straps: resistor level unless the device drives the pin
module spcl_straps(input wire [10:0] strap_i, drv_i, oe_i,
	output wire [10:0] level_o);
	assign level_o = (oe_i & drv_i) | (~oe_i & strap_i);
endmodule

// ---- verif/spcl_strap_latch_monitor.sv ----
`timescale 1ns/1ps
module spcl_monitor(input wire clk_i, reset_i, bcast_disable_wr_i,
	bcast_disable_wdata_i, straps_valid_o, broadcast_enable_o, addr_hit_o,
	back_to_back_o, config_reserved_o, reg16_bcast_disable_o,
	input wire [10:0] strap_pin_i, strap_pin_o, strap_pin_oe_o, func_out_i,
	input wire [4:0] mgmt_addr_i, strap_phy_address_o,
	input wire [2:0] config_mode_o);
default clocking @(posedge clk_i); endclocking
default disable iff (reset_i);
// ====
// Capture, then steady running
sequence s_rel; $fell(reset_i) ##2 1; endsequence
sequence s_run; straps_valid_o && $past(straps_valid_o); endsequence
property p_oe; !straps_valid_o |-> strap_pin_oe_o == 11'h000; endproperty
property p_drv; s_run |-> strap_pin_oe_o == 11'h7ff
	&& strap_pin_o == $past(func_out_i); endproperty
property p_adr; s_rel |-> straps_valid_o
	&& strap_phy_address_o == {2'h0, $past(strap_pin_i[2:0], 2)};
endproperty
property p_cfg; s_rel |-> config_mode_o == $past(strap_pin_i[5:3], 2);
endproperty
// Before the capture shows, the outputs hold the pull defaults
property p_dflt; $fell(reset_i) |=> !straps_valid_o
	&& strap_phy_address_o == 5'h01 && broadcast_enable_o
	&& config_mode_o == 3'h0 && !config_reserved_o; endproperty
property p_dec; straps_valid_o |-> back_to_back_o == (config_mode_o == 3'h6)
	&& config_reserved_o == (config_mode_o != 3'h0
	&& config_mode_o != 3'h6); endproperty
property p_hold; s_run |-> $stable(strap_phy_address_o)
	&& $stable(config_mode_o); endproperty
property p_wr; bcast_disable_wr_i ##1 !bcast_disable_wr_i |=>
	reg16_bcast_disable_o == $past(bcast_disable_wdata_i, 2); endproperty
property p_bd; reg16_bcast_disable_o |-> !broadcast_enable_o; endproperty
property p_hit; straps_valid_o && $past(straps_valid_o)
	&& $stable(broadcast_enable_o) |-> addr_hit_o ==
	($past(mgmt_addr_i) == strap_phy_address_o
	|| $past(mgmt_addr_i) == 5'h00 && broadcast_enable_o); endproperty
a_oe: assert property (p_oe) else $error("oe early");
a_drv: assert property (p_drv) else $error("pin drive");
a_adr: assert property (p_adr) else $error("address");
a_cfg: assert property (p_cfg) else $error("config");
a_dflt: assert property (p_dflt) else $error("defaults");
a_dec: assert property (p_dec) else $error("decode");
a_hold: assert property (p_hold) else $error("hold");
a_wr: assert property (p_wr) else $error("bcast write");
a_bd: assert property (p_bd) else $error("bcast off");
a_hit: assert property (p_hit) else $error("addr hit");
endmodule

// ---- verif/spcl_strap_latch_bench.sv ----
`timescale 1ns/1ps
module spcl_strap_latch_bench;
reg clk_i = 0, reset_i = 1, wr = 0, wd = 0;
reg [10:0] strap = 11'h301, fo = 11'h000;
reg [4:0] ma = 5'h00;
wire [10:0] pin, po, poe;
wire [4:0] adr;
wire [2:0] md;
wire sv, be, hit, b2b, rsv, wk, bd, iso, dup, an;
int err_total = 0, checked = 0, sd;
logic [15:0] q[$];
logic [2:0] qb[$];
reg sw = 0;
reg [10:0] cap = 11'h301;
always #25 clk_i = ~clk_i;
spcl_straps brd(.strap_i(strap), .drv_i(po), .oe_i(poe), .level_o(pin));
spcl_strap_latch uut(.clk_i(clk_i), .reset_i(reset_i), .strap_pin_i(pin),
	.strap_pin_o(po), .strap_pin_oe_o(poe), .func_out_i(fo),
	.bcast_disable_wr_i(wr), .bcast_disable_wdata_i(wd), .mgmt_addr_i(ma),
	.straps_valid_o(sv), .strap_phy_address_o(adr), .broadcast_enable_o(be),
	.addr_hit_o(hit), .config_mode_o(md), .back_to_back_o(b2b),
	.config_reserved_o(rsv), .reg16_wake_enable_o(wk),
	.reg16_bcast_disable_o(bd), .reg0_isolate_o(iso), .reg0_duplex_o(dup),
	.reg0_autoneg_o(an));
// ====
// Checking
function automatic [15:0] exp_of(input [10:0] s);
	exp_of = {2'h0, s[2:0], ~s[10], s[5:3], s[5:3] == 3'h6,
		s[5:3] != 3'h0 && s[5:3] != 3'h6, s[6], s[7], s[8], s[9], 1'b0};
endfunction
task chk(input string n, input [15:0] e, g);
	checked++;
	if (g !== e) begin
		err_total++;
		$display("[ERR] %s exp %h got %h", n, e, g);
	end
endtask
task chk_bus(input [2:0] e, g);
	checked++;
	if (g !== e) begin
		err_total++;
		$display("[ERR] bcast_hit exp %h got %h", e, g);
	end
endtask
task conclude;
	if (err_total == 0 && checked > 0) $display("Finished cleanly");
	else $display("Finished with errors");
	$finish;
endtask
// Sampled 1 ns after the edge, well before the next drive
always @(posedge clk_i) #1 if (sv === 1'b1) begin
	if (q.size() > 0)
		chk("straps", q.pop_front(),
			{adr, be, md, b2b, rsv, wk, iso, dup, an, bd});
	if (qb.size() > 0)
		chk_bus(qb.pop_front(), {bd, be, hit});
end
initial begin
	#100000;
	err_total++;
	conclude;
end
// ====
// Stimulus: default pulls, back-to-back code, then random straps
initial begin
	sd = $urandom(13);
	for (int i = 0; i < 12; i++) begin
		strap = i == 0 ? 11'h301 : i == 1 ? 11'h331 : $urandom;
		reset_i = 1;
		sw = 0;
		repeat (6) @(posedge clk_i);
		#5 reset_i = 0;
		cap = strap;
		q.push_back(exp_of(strap));
		repeat (2) @(posedge clk_i);
		// Straps keep moving after capture and must be ignored
		repeat (30) @(posedge clk_i) begin
			#5 wr = $urandom % 4 == 0;
			wd = $urandom;
			ma = $urandom % 10;
			fo = $urandom;
			strap = $urandom;
			// Next edge shows the software bit from before this write
			qb.push_back({sw, ~(cap[10] | sw), ma == {2'h0, cap[2:0]} ||
				ma == 5'h00 && !(cap[10] | sw)});
			if (wr) sw = wd;
		end
		// One more edge so the last note is checked before reset
		@(posedge clk_i) #5 wr = 0;
	end
	conclude;
end
endmodule
bind spcl_strap_latch spcl_monitor mon(.*);
